// ===== verilog/rvc_regs.sv
// Rail voltage code register bank with sleep-aware target selection
//
// Summary of operation
// [R1] Offset 95h: rail four sleep code, bits 7:1
// [R2] Offset 96h: rail five normal code, bits 7:1
// [R3] Bit 0 set: passive decay, clear: slew
// [R4] Offset 97h: rail five sleep code, bits 7:1
// [R5] Offset 98h: rail six normal code, bits 7:1
// [R6] Offset 99h: rail six sleep code, bits 7:1
// [R7] Offset 9Ah bits 7:4: linear regulator sleep code
// [R8] Offset 9Ah bits 3:0: linear regulator normal code
// [R9] Sleep enabled and assigned input low: sleep code
// [R10] Sleep register bit 0 ignores writes, reads zero
// [R11] Reset clears registers; first edge after reset loads programmed default configuration
`timescale 1ns/1ps
`include "rvc_defines.svh"

module rvc_regs
   import rvc_pkg::*;
#(
   parameter int DATA_W = `RVC_BYTE_W
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Byte register port from the serial engine
   input wire rvc_bus_req_t i_req,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   // Default configuration and neighbouring state
   input wire rvc_defaults_t i_defaults,
   input wire logic [6:0] i_rail4_normal_code,
   input wire rvc_sleep_cfg_t [3:0] i_sleep_cfg,
   // Sleep control pins
   input wire logic i_sleep_control_input_one,
   input wire logic i_sleep_control_input_two,
   // Regulation targets
   output logic [6:0] o_rail4_target_code,
   output logic [6:0] o_rail5_target_code,
   output logic [6:0] o_rail6_target_code,
   output logic [3:0] o_linreg_a2_target_code,
   output logic o_rail5_passive_ramp_sel,
   output logic o_rail6_passive_ramp_sel,
   output logic o_defaults_loaded
);

   // The bank is byte wide by construction
   if (DATA_W != `RVC_BYTE_W) begin : g_bad_width
      $error("rvc_regs: DATA_W must be 8");
   end

   rvc_state_t state_q;
   rvc_state_t state_d;
   logic [7:0] regs_q [`RVC_NUM_REGS];
   logic [7:0] regs_d [`RVC_NUM_REGS];
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic rvalid_q;
   logic rvalid_d;
   logic hit;
   logic [2:0] idx;
   logic [7:0] wmask;

   // The slot index is three bits wide, which caps the bank size
   if (`RVC_NUM_REGS > (1 << $bits(idx))) begin : g_bad_slots
      $error("rvc_regs: too many register slots for the index");
   end

   // Address decode; sleep registers keep bit 0 out of the write mask
   // Unmapped offsets clear the mask and the hit, so a stray write never lands
   always_comb begin
      hit = 1'b1;
      idx = `RVC_IDX_R4_SLP;
      wmask = `RVC_MASK_SLP;
      if (i_req.addr == `RVC_OFF_R4_SLP) begin
         idx = `RVC_IDX_R4_SLP; // [R1] [R10]
      end else if (i_req.addr == `RVC_OFF_R5_NRM) begin
         idx = `RVC_IDX_R5_NRM; // [R2] [R3]
         wmask = `RVC_MASK_FULL;
      end else if (i_req.addr == `RVC_OFF_R5_SLP) begin
         idx = `RVC_IDX_R5_SLP; // [R4] [R10]
      end else if (i_req.addr == `RVC_OFF_R6_NRM) begin
         idx = `RVC_IDX_R6_NRM; // [R5] [R3]
         wmask = `RVC_MASK_FULL;
      end else if (i_req.addr == `RVC_OFF_R6_SLP) begin
         idx = `RVC_IDX_R6_SLP; // [R6] [R10]
      end else if (i_req.addr == `RVC_OFF_A2_PAIR) begin
         idx = `RVC_IDX_A2_PAIR; // [R7] [R8]
         wmask = `RVC_MASK_FULL;
      end else begin
         hit = 1'b0;
         wmask = `RVC_BYTE_ZERO;
      end
   end

   // Register contents: one default load, then host writes
   // A host write in the load cycle is dropped: the defaults own that edge
   always_comb begin
      state_d = state_q;
      regs_d = regs_q;
      case (state_q)
         RVC_ST_LOAD: begin
            // Loaded here, not under reset, so the flops reset to constants
            regs_d[`RVC_IDX_R4_SLP] = i_defaults.r4_slp & `RVC_MASK_SLP; // [R11] [R10]
            regs_d[`RVC_IDX_R5_NRM] = i_defaults.r5_nrm; // [R11]
            regs_d[`RVC_IDX_R5_SLP] = i_defaults.r5_slp & `RVC_MASK_SLP; // [R11] [R10]
            regs_d[`RVC_IDX_R6_NRM] = i_defaults.r6_nrm; // [R11]
            regs_d[`RVC_IDX_R6_SLP] = i_defaults.r6_slp & `RVC_MASK_SLP; // [R11] [R10]
            regs_d[`RVC_IDX_A2_PAIR] = i_defaults.a2_pair; // [R11]
            state_d = RVC_ST_RUN;
         end
         RVC_ST_RUN: begin
            if (i_req.wr && hit) begin
               regs_d[idx] = (regs_q[idx] & ~wmask) | (i_req.wdata & wmask); // [R10]
            end
         end
         default: begin
            state_d = RVC_ST_LOAD;
         end
      endcase
   end

   // Read answer one cycle after the request; unmapped reads give zero
   // A read and a write in one cycle answer with the byte before the write
   always_comb begin
      rvalid_d = i_req.rd;
      rdata_d = `RVC_BYTE_ZERO;
      if (i_req.rd && hit) begin
         rdata_d = regs_q[idx];
      end
   end

   // Bank flops; reset clears to constants and the defaults follow one edge later,
   // which keeps the asynchronous branch free of input-dependent values
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= RVC_ST_LOAD;
         rdata_q <= `RVC_BYTE_ZERO;
         rvalid_q <= 1'b0;
         for (int k = 0; k < `RVC_NUM_REGS; k++) begin
            regs_q[k] <= `RVC_BYTE_ZERO;
         end
      end else begin
         state_q <= state_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         regs_q <= regs_d;
      end
   end

   // Sleep state per rail: enabled and assigned input pulled low
   logic [3:0] sleep_act;
   logic [6:0] nrm_code [`RVC_NUM_RAILS];
   logic [6:0] slp_code [`RVC_NUM_RAILS];
   logic [6:0] tgt_d [`RVC_NUM_RAILS];
   logic [6:0] tgt_q [`RVC_NUM_RAILS];
   logic [3:0] a2_d;
   logic [3:0] a2_q;
   logic [1:0] ramp_d;
   logic [1:0] ramp_q;
   logic loaded_d;
   logic loaded_q;

   // Sleep decode per output, then the code fields of each converter rail
   // Pins are taken as synchronous here; an asynchronous pin needs its own stage
   always_comb begin
      for (int r = 0; r < $bits(sleep_act); r++) begin
         sleep_act[r] = i_sleep_cfg[r].en && !(i_sleep_cfg[r].pin_two ?
            i_sleep_control_input_two : i_sleep_control_input_one); // [R9]
      end
      nrm_code[0] = i_rail4_normal_code;
      slp_code[0] = regs_q[`RVC_IDX_R4_SLP][`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R1]
      nrm_code[1] = regs_q[`RVC_IDX_R5_NRM][`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R2]
      slp_code[1] = regs_q[`RVC_IDX_R5_SLP][`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R4]
      nrm_code[2] = regs_q[`RVC_IDX_R6_NRM][`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R5]
      slp_code[2] = regs_q[`RVC_IDX_R6_SLP][`RVC_CODE_MSB:`RVC_CODE_LSB]; // [R6]
   end

   // Target code per converter rail
   // Sleep wins only while enabled and its assigned pin is held low
   for (genvar g = 0; g < `RVC_NUM_RAILS; g++) begin : g_rail
      assign tgt_d[g] = sleep_act[g] ? slp_code[g] : nrm_code[g]; // [R9]
   end

   // Linear regulator target, ramp selectors and load status
   always_comb begin
      a2_d = sleep_act[3] ?
         regs_q[`RVC_IDX_A2_PAIR][`RVC_A2_SLP_MSB:`RVC_A2_SLP_LSB] : // [R7]
         regs_q[`RVC_IDX_A2_PAIR][`RVC_A2_NRM_MSB:`RVC_A2_NRM_LSB]; // [R8]
      // A set bit lets the rail fall passively; load sets the fall time
      ramp_d[0] = regs_q[`RVC_IDX_R5_NRM][`RVC_DECAY_BIT]; // [R3]
      ramp_d[1] = regs_q[`RVC_IDX_R6_NRM][`RVC_DECAY_BIT]; // [R3]
      loaded_d = (state_q == RVC_ST_RUN);
   end

   // Target flops: a pin or register change reaches the rails one edge later
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < `RVC_NUM_RAILS; k++) begin
            tgt_q[k] <= `RVC_CODE_ZERO;
         end
         a2_q <= `RVC_A2_ZERO;
         ramp_q <= 2'h0;
         loaded_q <= 1'b0;
      end else begin
         tgt_q <= tgt_d;
         a2_q <= a2_d;
         ramp_q <= ramp_d;
         loaded_q <= loaded_d;
      end
   end

   // Outputs straight from flops
   // Decode glitches never reach the converters, at the cost of one cycle of lag
   assign o_rdata = rdata_q;
   assign o_rvalid = rvalid_q;
   assign o_rail4_target_code = tgt_q[0];
   assign o_rail5_target_code = tgt_q[1];
   assign o_rail6_target_code = tgt_q[2];
   assign o_linreg_a2_target_code = a2_q;
   assign o_rail5_passive_ramp_sel = ramp_q[0];
   assign o_rail6_passive_ramp_sel = ramp_q[1];
   assign o_defaults_loaded = loaded_q;

endmodule : rvc_regs

// ===== inc/rvc_defines.svh
// Offsets, field positions and reset constants of the rail voltage code registers
`ifndef RVC_DEFINES_SVH
`define RVC_DEFINES_SVH

// Register offsets on the byte register port
`define RVC_OFF_R4_SLP 8'h95
`define RVC_OFF_R5_NRM 8'h96
`define RVC_OFF_R5_SLP 8'h97
`define RVC_OFF_R6_NRM 8'h98
`define RVC_OFF_R6_SLP 8'h99
`define RVC_OFF_A2_PAIR 8'h9A

// Storage slots inside the bank
`define RVC_NUM_REGS 6
`define RVC_IDX_R4_SLP 3'h0
`define RVC_IDX_R5_NRM 3'h1
`define RVC_IDX_R5_SLP 3'h2
`define RVC_IDX_R6_NRM 3'h3
`define RVC_IDX_R6_SLP 3'h4
`define RVC_IDX_A2_PAIR 3'h5

// Field positions
`define RVC_BYTE_W 8
`define RVC_CODE_MSB 7
`define RVC_CODE_LSB 1
`define RVC_CODE_W 7
`define RVC_DECAY_BIT 0
`define RVC_A2_SLP_MSB 7
`define RVC_A2_SLP_LSB 4
`define RVC_A2_NRM_MSB 3
`define RVC_A2_NRM_LSB 0
`define RVC_A2_W 4
`define RVC_NUM_RAILS 3

// Writable bit masks and constants
`define RVC_MASK_SLP 8'hFE
`define RVC_MASK_FULL 8'hFF
`define RVC_BYTE_ZERO 8'h00
`define RVC_CODE_ZERO 7'h00
`define RVC_A2_ZERO 4'h0

`endif

// ===== inc/rvc_pkg.sv
// Types shared by the rail voltage code register bank
package rvc_pkg;

   // Bank sequencing: defaults load once after reset, then normal access
   typedef enum logic [1:0] {
      RVC_ST_LOAD = 2'b01,
      RVC_ST_RUN = 2'b10
   } rvc_state_t;

   // One byte access from the serial port engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rvc_bus_req_t;

   // Programmed default configuration, one byte per register
   typedef struct packed {
      logic [7:0] r4_slp;
      logic [7:0] r5_nrm;
      logic [7:0] r5_slp;
      logic [7:0] r6_nrm;
      logic [7:0] r6_slp;
      logic [7:0] a2_pair;
   } rvc_defaults_t;

   // Per-rail sleep setup: enable and which sleep input is assigned
   typedef struct packed {
      logic en;
      logic pin_two;
   } rvc_sleep_cfg_t;

endpackage : rvc_pkg

// ===== bench/rvc_regs_monitor.sv
// Port-level checks of the rail voltage code register bank
`timescale 1ns/1ps
module rvc_regs_monitor
   import rvc_pkg::*;
(
   // Clock, reset and inputs
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire rvc_bus_req_t i_req,
   input wire logic [6:0] i_rail4_normal_code,
   input wire rvc_sleep_cfg_t [3:0] i_sleep_cfg,
   // Watched outputs
   input wire logic [7:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic [6:0] o_rail4_target_code,
   input wire logic [3:0] o_linreg_a2_target_code,
   input wire logic o_rail5_passive_ramp_sel,
   input wire logic o_defaults_loaded
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // Defaults copy on edge one, so the flag is seen only from the third edge
   sequence s_load;
      !o_defaults_loaded [*2] ##1 o_defaults_loaded;
   endsequence
   a_load_after_reset: assert property ($fell(i_rst) |-> s_load)
      else $error("defaults flag late or early");
   a_loaded_hold: assert property (o_defaults_loaded |=> o_defaults_loaded)
      else $error("defaults flag dropped");
   a_read_answer: assert property (i_req.rd |=> o_rvalid)
      else $error("read not answered");
   a_valid_cause: assert property (o_rvalid |-> $past(i_req.rd))
      else $error("read valid without read");
   a_sleep_bit_zero: assert property ((i_req.rd && i_req.addr inside {8'h95, 8'h97, 8'h99})
      |=> !o_rdata[0])
      else $error("reserved bit read as one");
   a_unmapped_zero: assert property ((i_req.rd && !(i_req.addr inside {[8'h95:8'h9A]}))
      |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ramp5_follow: assert property ((i_req.wr && i_req.addr == 8'h96 && o_defaults_loaded)
      |-> ##2 o_rail5_passive_ramp_sel == $past(i_req.wdata[0], 2))
      else $error("decay select not taken");
   a_a2_normal: assert property ((i_req.wr && i_req.addr == 8'h9A && o_defaults_loaded
      && !i_sleep_cfg[3].en) ##1 !i_sleep_cfg[3].en
      |=> o_linreg_a2_target_code == $past(i_req.wdata[3:0], 2))
      else $error("linear normal code not used");
   a_rail4_normal: assert property ((!i_sleep_cfg[0].en && o_defaults_loaded)
      |=> o_rail4_target_code == $past(i_rail4_normal_code))
      else $error("rail four not on normal code");
endmodule : rvc_regs_monitor

// ===== bench/rvc_regs_bench.sv
// Self-checking bench of the rail voltage code register bank
`timescale 1ns/1ps
module rvc_regs_bench
   import rvc_pkg::*;
;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   rvc_bus_req_t req = '0;
   rvc_defaults_t defs = '0;
   logic [6:0] r4n = 7'h00;
   rvc_sleep_cfg_t [3:0] cfg = '0;
   logic p1 = 1'b1;
   logic p2 = 1'b1;
   logic [7:0] rdata;
   logic rvalid, rs5, rs6, loaded;
   logic [6:0] t4, t5, t6;
   logic [3:0] ta2;
   logic [7:0] mem [6];
   int errors = 0;
   int comparisons = 0;
   rvc_regs i_rvc_regs (.i_core_clk, .i_rst, .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
      .i_defaults(defs), .i_rail4_normal_code(r4n), .i_sleep_cfg(cfg),
      .i_sleep_control_input_one(p1), .i_sleep_control_input_two(p2),
      .o_rail4_target_code(t4), .o_rail5_target_code(t5), .o_rail6_target_code(t6),
      .o_linreg_a2_target_code(ta2), .o_rail5_passive_ramp_sel(rs5),
      .o_rail6_passive_ramp_sel(rs6), .o_defaults_loaded(loaded));
   // Free-running core clock
   always #25 i_core_clk = ~i_core_clk;
   // Writable bits: sleep registers keep bit 0 at zero
   function automatic logic [7:0] mk(int i);
      return (i % 2 == 0 && i < 5) ? 8'hFE : 8'hFF;
   endfunction : mk
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic results;
      if (errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   // One byte access; read answer is sampled once the answering edge has landed
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk) req <= '{wr, !wr, a, d};
      @(posedge i_core_clk) req <= '0;
      #1;
      if (!wr) begin
         chk({7'h00, rvalid}, 8'h01);
         chk(rdata, (a inside {[8'h95:8'h9A]}) ? mem[a - 8'h95] : 8'h00);
      end else if (a inside {[8'h95:8'h9A]}) begin
         mem[a - 8'h95] = d & mk(a - 8'h95);
      end
   endtask : acc
   // Targets follow the sleep pins one edge late, registers one more
   task automatic tgt;
      logic [3:0] s;
      repeat (2) @(posedge i_core_clk);
      #1;
      for (int i = 0; i < 4; i++) s[i] = cfg[i].en && !(cfg[i].pin_two ? p2 : p1);
      chk({1'b0, t4}, {1'b0, s[0] ? mem[0][7:1] : r4n});
      chk({1'b0, t5}, {1'b0, mem[s[1] ? 2 : 1][7:1]});
      chk({1'b0, t6}, {1'b0, mem[s[2] ? 4 : 3][7:1]});
      chk({4'h0, ta2}, {4'h0, s[3] ? mem[5][7:4] : mem[5][3:0]});
      chk({6'h00, rs6, rs5}, {6'h00, mem[3][0], mem[1][0]});
   endtask : tgt
   // Two runs, the second reset lands in mid-run with new defaults
   initial begin
      void'($urandom(72356));
      for (int run = 0; run < 2; run++) begin
         @(posedge i_core_clk) begin
            i_rst <= 1'b1;
            defs <= 48'({$urandom, $urandom});
            r4n <= 7'($urandom);
            cfg <= '0;
         end
         repeat (20) @(posedge i_core_clk);
         i_rst <= 1'b0;
         for (int i = 0; i < 6; i++) mem[i] = defs[47 - 8 * i -: 8] & mk(i);
         repeat (3) @(posedge i_core_clk);
         #1;
         chk({7'h00, loaded}, 8'h01);
         for (int i = 0; i < 6; i++) acc(1'b0, 8'(8'h95 + i), 8'h00);
         tgt;
         for (int i = -1; i < 7; i++) acc(1'b1, 8'(8'h95 + i), 8'($urandom));
         for (int i = -1; i < 7; i++) acc(1'b0, 8'(8'h95 + i), 8'h00);
         tgt;
         for (int k = 0; k < 4; k++) begin
            @(posedge i_core_clk) begin
               cfg <= 8'($urandom) | 8'hAA;
               p1 <= k[0];
               p2 <= k[1];
            end
            tgt;
         end
      end
      results;
   end
   // Cut a hung run short
   initial begin
      #(50 * 5000);
      errors++;
      results;
   end
endmodule : rvc_regs_bench
bind rvc_regs rvc_regs_monitor i_rvc_regs_monitor (.i_core_clk, .i_rst, .i_req,
   .i_rail4_normal_code, .i_sleep_cfg, .o_rdata, .o_rvalid, .o_rail4_target_code,
   .o_linreg_a2_target_code, .o_rail5_passive_ramp_sel, .o_defaults_loaded);
